/* cpurf_core.v */
// CPU programmer-visible register file with flag word and reset entry
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_defs.vh"

module cpurf_core #(
   parameter RESET_VECTOR = 20'hFFFFC
) (
   // System
   input wire clock,
   input wire sys_rst,
   // Reset pin, active low, asynchronous to clock
   input wire resetPin_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // ALU result flags, valid with aluUpdate
   input wire aluUpdate,
   input wire aluCarry,
   input wire aluZero,
   input wire aluSign,
   input wire aluOverflow,
   // Instruction completion and interrupt events
   input wire instrDone,
   input wire hwIntAck,
   input wire swIntExec,
   input wire [5:0] swIntNum,
   input wire irqRequest,
   input wire [2:0] irqPriority,
   // Status outputs
   output reg irqAccept,
   output reg stepIrq,
   output reg fetchStart,
   output reg [19:0] fetchAddr,
   output reg cpuInReset,
   output reg ramPreserve
);

   // Reset sequencing states
   localparam ST_RESET = 3'b001;
   localparam ST_FETCH = 3'b010;
   localparam ST_RUN = 3'b100;

   // Banked storage is not cleared by reset, like a RAM-based register
   // file; software must load a register before it relies on its value
   reg [15:0] bankData [0:1][0:3];
   reg [15:0] bankAddr [0:1][0:1];
   reg [15:0] bankFb [0:1];
   reg [15:0] sbReg;
   reg [19:0] pcReg;
   reg [19:0] intbReg;
   reg [15:0] uspReg;
   reg [15:0] ispReg;
   reg [15:0] flag_reg;
   reg [15:0] flag_next;
   reg [4:0] sel_reg;
   reg [2:0] state_reg;
   reg [`CPURF_RST_CNT_W-1:0] rstCnt_reg;
   reg pinS1, pinS2, pinS3;
   reg hwRstLevel;
   reg swRst_reg;
   reg [31:0] rdMux;
   reg [31:0] rdReg;

   wire bank = flag_reg[`CPURF_FLG_B];
   // Writes land only on the completing access edge, so a side effect
   // such as the software reset pulse fires once per transfer
   wire wrEn = psel & penable & pwrite & pready;
   wire rdEn = psel & penable & ~pwrite;
   wire anyRst = sys_rst | hwRstLevel | swRst_reg;
   wire uSel = flag_reg[`CPURF_FLG_U];
   wire wrData = wrEn & (paddr == `CPURF_OFS_DATA);
   wire [2:0] cpu_priority_level = flag_reg[`CPURF_FLG_IPL_HI:`CPURF_FLG_IPL_LO];

   // Reserved flag bits are forced to zero wherever the word is loaded
   function [15:0] flagClean;
      input [15:0] v;
      begin
         flagClean = v & `CPURF_FLG_MASK;
      end
   endfunction

   // Mapped offsets only; any other address answers with an error
   function addrKnown;
      input [11:0] a;
      begin
         if (a == `CPURF_OFS_SEL) begin
            addrKnown = 1'b1;
         end else if (a == `CPURF_OFS_DATA) begin
            addrKnown = 1'b1;
         end else if (a == `CPURF_OFS_FLAG) begin
            addrKnown = 1'b1;
         end else if (a == `CPURF_OFS_MODE) begin
            addrKnown = 1'b1;
         end else if (a == `CPURF_OFS_STAT) begin
            addrKnown = 1'b1;
         end else begin
            addrKnown = 1'b0;
         end
      end
   endfunction

   // Pin synchroniser; a level counts once the second and third stages agree
   always @(posedge clock) begin
      pinS1 <= resetPin_n;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
   end

   // Pin must be seen low for the minimum cycles before reset is taken;
   // shorter glitches are ignored
   always @(posedge clock) begin
      if (sys_rst) begin
         rstCnt_reg <= {`CPURF_RST_CNT_W{1'b0}};
         hwRstLevel <= 1'b0;
      end else if (pinS2 == pinS3 && !pinS3) begin
         if (rstCnt_reg != `CPURF_RST_MIN_CYCLES - 1) begin
            rstCnt_reg <= rstCnt_reg + 1'b1;
         end else begin
            hwRstLevel <= 1'b1;
         end
      end else if (pinS2 == pinS3) begin
         rstCnt_reg <= {`CPURF_RST_CNT_W{1'b0}};
         hwRstLevel <= 1'b0;
      end
   end

   // Flag word next value; acknowledge clears take precedence over writes
   always @* begin
      flag_next = flag_reg;
      if (wrEn && paddr == `CPURF_OFS_FLAG) begin
         flag_next = flagClean(pwdata[15:0]);
      end
      if (aluUpdate) begin
         flag_next[`CPURF_FLG_C] = aluCarry;
         flag_next[`CPURF_FLG_Z] = aluZero;
         flag_next[`CPURF_FLG_S] = aluSign;
         flag_next[`CPURF_FLG_O] = aluOverflow;
      end
      if (hwIntAck || (swIntExec && swIntNum < 6'h20)) begin
         flag_next[`CPURF_FLG_U] = 1'b0;
      end
      if (hwIntAck) begin
         flag_next[`CPURF_FLG_D] = 1'b0;
         flag_next[`CPURF_FLG_I] = 1'b0;
      end
   end

   // One reset path serves pin, system and software sources alike
   always @(posedge clock) begin
      if (anyRst) begin
         flag_reg <= `CPURF_FLG_RESET;
         state_reg <= ST_RESET;
         pcReg <= 20'h00000;
      end else begin
         flag_reg <= flag_next;
         case (state_reg)
            ST_RESET: begin
               state_reg <= ST_FETCH;
            end
            ST_FETCH: begin
               pcReg <= RESET_VECTOR;
               state_reg <= ST_RUN;
            end
            ST_RUN: begin
               if (wrData && sel_reg == `CPURF_SEL_PC) begin
                  pcReg <= pwdata[19:0];
               end
            end
            default: begin
               state_reg <= ST_RESET;
            end
         endcase
      end
   end

   // Software reset pulse; RAM lives outside and is never touched here
   // One cycle is enough, since every reset branch is synchronous
   always @(posedge clock) begin
      if (sys_rst) begin
         swRst_reg <= 1'b0;
      end else begin
         swRst_reg <= wrEn && paddr == `CPURF_OFS_MODE
            && pwdata[`CPURF_MODE_SWRST];
      end
   end

   // General registers: written through the selector window
   always @(posedge clock) begin
      if (anyRst) begin
         sel_reg <= 5'h00;
         sbReg <= 16'h0000;
         intbReg <= 20'h00000;
         uspReg <= 16'h0000;
         ispReg <= 16'h0000;
      end else begin
         if (wrEn && paddr == `CPURF_OFS_SEL) begin
            sel_reg <= pwdata[4:0];
         end
         if (wrData) begin
            case (sel_reg)
               `CPURF_SEL_R0, `CPURF_SEL_R1, `CPURF_SEL_R2,
               `CPURF_SEL_R3: begin
                  bankData[bank][sel_reg[1:0]] <= pwdata[15:0];
               end
               `CPURF_SEL_A0, `CPURF_SEL_A1: begin
                  bankAddr[bank][sel_reg[0]] <= pwdata[15:0];
               end
               `CPURF_SEL_FB: begin
                  bankFb[bank] <= pwdata[15:0];
               end
               `CPURF_SEL_SB: begin
                  sbReg <= pwdata[15:0];
               end
               `CPURF_SEL_VECTOR_TABLE_BASE: begin
                  intbReg <= pwdata[19:0];
               end
               `CPURF_SEL_USP: begin
                  uspReg <= pwdata[15:0];
               end
               `CPURF_SEL_ISP: begin
                  ispReg <= pwdata[15:0];
               end
               `CPURF_SEL_SP: begin
                  if (uSel) begin
                     uspReg <= pwdata[15:0];
                  end else begin
                     ispReg <= pwdata[15:0];
                  end
               end
               `CPURF_SEL_R0L: begin
                  bankData[bank][0][7:0] <= pwdata[7:0];
               end
               `CPURF_SEL_R0H: begin
                  bankData[bank][0][15:8] <= pwdata[7:0];
               end
               `CPURF_SEL_R1L: begin
                  bankData[bank][1][7:0] <= pwdata[7:0];
               end
               `CPURF_SEL_R1H: begin
                  bankData[bank][1][15:8] <= pwdata[7:0];
               end
               `CPURF_SEL_DATA_PAIR_LOW: begin
                  bankData[bank][0] <= pwdata[15:0];
                  bankData[bank][2] <= pwdata[31:16];
               end
               `CPURF_SEL_DATA_PAIR_HIGH: begin
                  bankData[bank][1] <= pwdata[15:0];
                  bankData[bank][3] <= pwdata[31:16];
               end
               `CPURF_SEL_ADDR_REG_PAIR: begin
                  bankAddr[bank][0] <= pwdata[15:0];
                  bankAddr[bank][1] <= pwdata[31:16];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read selection of the register named by the selector
   always @* begin
      rdReg = 32'h00000000;
      case (sel_reg)
         `CPURF_SEL_R0, `CPURF_SEL_R1, `CPURF_SEL_R2, `CPURF_SEL_R3:
            rdReg = {16'h0000, bankData[bank][sel_reg[1:0]]};
         `CPURF_SEL_A0, `CPURF_SEL_A1:
            rdReg = {16'h0000, bankAddr[bank][sel_reg[0]]};
         `CPURF_SEL_FB: rdReg = {16'h0000, bankFb[bank]};
         `CPURF_SEL_SB: rdReg = {16'h0000, sbReg};
         `CPURF_SEL_PC: rdReg = {12'h000, pcReg};
         `CPURF_SEL_VECTOR_TABLE_BASE: rdReg = {12'h000, intbReg};
         `CPURF_SEL_USP: rdReg = {16'h0000, uspReg};
         `CPURF_SEL_ISP: rdReg = {16'h0000, ispReg};
         `CPURF_SEL_SP: rdReg = {16'h0000, uSel ? uspReg : ispReg};
         `CPURF_SEL_R0L: rdReg = {24'h000000, bankData[bank][0][7:0]};
         `CPURF_SEL_R0H: rdReg = {24'h000000, bankData[bank][0][15:8]};
         `CPURF_SEL_R1L: rdReg = {24'h000000, bankData[bank][1][7:0]};
         `CPURF_SEL_R1H: rdReg = {24'h000000, bankData[bank][1][15:8]};
         `CPURF_SEL_DATA_PAIR_LOW: rdReg = {bankData[bank][2], bankData[bank][0]};
         `CPURF_SEL_DATA_PAIR_HIGH: rdReg = {bankData[bank][3], bankData[bank][1]};
         `CPURF_SEL_ADDR_REG_PAIR: rdReg = {bankAddr[bank][1], bankAddr[bank][0]};
         default: rdReg = 32'h00000000;
      endcase
   end

   always @* begin
      if (paddr == `CPURF_OFS_SEL) begin
         rdMux = {27'h0000000, sel_reg};
      end else if (paddr == `CPURF_OFS_DATA) begin
         rdMux = rdReg;
      end else if (paddr == `CPURF_OFS_FLAG) begin
         rdMux = {16'h0000, flagClean(flag_reg)};
      end else if (paddr == `CPURF_OFS_MODE) begin
         // The reset bit is a one-shot command and reads back as zero
         rdMux = 32'h00000000;
      end else if (paddr == `CPURF_OFS_STAT) begin
         rdMux = {29'h00000000, state_reg};
      end else begin
         rdMux = 32'h00000000;
      end
   end

   // APB answer: one wait state, ready on the second access cycle
   // pslverr only means something together with pready, so both are
   // raised on the same edge and dropped together
   always @(posedge clock) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addrKnown(paddr);
         if (rdEn && !pready) begin
            prdata <= rdMux;
         end
      end
   end

   // Event outputs
   // The fetch address is held at the reset vector outside reset and cleared to zero during any reset,
   // so a fetch unit may latch it on the pulse without its own copy
   always @(posedge clock) begin
      if (anyRst) begin
         irqAccept <= 1'b0;
         stepIrq <= 1'b0;
         fetchStart <= 1'b0;
         fetchAddr <= 20'h00000;
         cpuInReset <= 1'b1;
         ramPreserve <= 1'b0;
      end else begin
         irqAccept <= irqRequest && flag_reg[`CPURF_FLG_I]
            && irqPriority > cpu_priority_level;
         stepIrq <= instrDone && flag_reg[`CPURF_FLG_D];
         fetchStart <= state_reg == ST_FETCH;
         fetchAddr <= RESET_VECTOR;
         cpuInReset <= state_reg == ST_RESET;
         ramPreserve <= 1'b1;
      end
   end

endmodule
`default_nettype wire

/* cpurf_defs.vh */
// Constants for the CPU register file, flag word and reset entry
`ifndef CPURF_DEFS_VH
`define CPURF_DEFS_VH
// APB byte offsets
`define CPURF_OFS_SEL 12'h000
`define CPURF_OFS_DATA 12'h004
`define CPURF_OFS_FLAG 12'h008
`define CPURF_OFS_MODE 12'h00C
`define CPURF_OFS_STAT 12'h010
// Register selector codes
`define CPURF_SEL_R0 5'h00
`define CPURF_SEL_R1 5'h01
`define CPURF_SEL_R2 5'h02
`define CPURF_SEL_R3 5'h03
`define CPURF_SEL_A0 5'h04
`define CPURF_SEL_A1 5'h05
`define CPURF_SEL_FB 5'h06
`define CPURF_SEL_SB 5'h07
`define CPURF_SEL_PC 5'h08
`define CPURF_SEL_VECTOR_TABLE_BASE 5'h09
`define CPURF_SEL_USP 5'h0A
`define CPURF_SEL_ISP 5'h0B
`define CPURF_SEL_SP 5'h0C
`define CPURF_SEL_R0L 5'h0D
`define CPURF_SEL_R0H 5'h0E
`define CPURF_SEL_R1L 5'h0F
`define CPURF_SEL_R1H 5'h10
`define CPURF_SEL_DATA_PAIR_LOW 5'h11
`define CPURF_SEL_DATA_PAIR_HIGH 5'h12
`define CPURF_SEL_ADDR_REG_PAIR 5'h13
// Flag word bit positions
`define CPURF_FLG_C 0
`define CPURF_FLG_D 1
`define CPURF_FLG_Z 2
`define CPURF_FLG_S 3
`define CPURF_FLG_B 4
`define CPURF_FLG_O 5
`define CPURF_FLG_I 6
`define CPURF_FLG_U 7
`define CPURF_FLG_IPL_LO 12
`define CPURF_FLG_IPL_HI 14
`define CPURF_FLG_MASK 16'h70FF
`define CPURF_FLG_RESET 16'h0000
// Mode control: software reset bit
`define CPURF_MODE_SWRST 3
// Reset timing
`define CPURF_RST_MIN_CYCLES 20
`define CPURF_RST_CNT_W 5
`endif

/* cpurf_core_props.sv */
// Port-level assertions for the CPU register file block
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_defs.vh"
module cpurf_core_props #(
   parameter RESET_VECTOR = 20'hFFFFC
) (
   // System
   input wire logic clock,
   input wire logic sys_rst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events and status
   input wire logic instrDone,
   input wire logic irqRequest,
   input wire logic [2:0] irqPriority,
   input wire logic irqAccept,
   input wire logic stepIrq,
   input wire logic fetchStart,
   input wire logic [19:0] fetchAddr,
   input wire logic cpuInReset
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // First access edge of a transfer, before the answer
   wire accessEdge = psel && penable && !pready;
   ready_after_access_a: assert property (accessEdge |=> pready)
      else $error("pready missing after access");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   unmapped_error_a: assert property (accessEdge && paddr > `CPURF_OFS_STAT
      |=> pready && pslverr)
      else $error("no error for unmapped address");
   flag_reserved_zero_a: assert property (accessEdge && !pwrite &&
      paddr == `CPURF_OFS_FLAG |=> prdata[31:15] == 0 && prdata[11:8] == 0)
      else $error("reserved flag bits read nonzero");
   step_cause_a: assert property (stepIrq |-> $past(instrDone))
      else $error("step interrupt without instruction end");
   irq_cause_a: assert property (irqAccept |->
      $past(irqRequest) && $past(irqPriority) != 3'h0)
      else $error("interrupt accepted without request");
   fetch_after_reset_a: assert property ($fell(sys_rst) |->
      ##[1:3] fetchStart && fetchAddr == RESET_VECTOR)
      else $error("no reset vector fetch");
   in_reset_a: assert property (disable iff (1'b0) sys_rst |=> cpuInReset)
      else $error("reset state not shown");
   soft_reset_a: assert property (accessEdge && pwrite &&
      paddr == `CPURF_OFS_MODE && pwdata[3] |-> ##[1:4] cpuInReset)
      else $error("software reset not taken");
endmodule
bind cpurf_core cpurf_core_props #(.RESET_VECTOR(RESET_VECTOR)) i_props (
   .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .instrDone(instrDone),
   .irqRequest(irqRequest), .irqPriority(irqPriority),
   .irqAccept(irqAccept), .stepIrq(stepIrq), .fetchStart(fetchStart),
   .fetchAddr(fetchAddr), .cpuInReset(cpuInReset));
`default_nettype wire

/* tb_cpurf_core.sv */
// Self-checking testbench for the CPU register file block
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_defs.vh"
module tb_cpurf_core;
   localparam logic [19:0] RV = 20'h12344;
   typedef struct {logic [31:0] e; logic [31:0] m; logic r;} cpurf_note_t;
   cpurf_note_t notes[$];
   cpurf_note_t n;
   logic clock = '0;
   logic sys_rst = '1;
   logic resetPin_n = '1;
   logic psel = '0;
   logic penable = '0;
   logic pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic aluUpdate = '0, aluCarry = '0, aluZero = '0;
   logic aluSign = '0, aluOverflow = '0, instrDone = '0, hwIntAck = '0;
   logic swIntExec = '0, irqRequest = '0;
   logic [5:0] swIntNum = '0;
   logic [2:0] irqPriority = '0;
   wire [31:0] prdata;
   wire [19:0] fetchAddr;
   wire pready, pslverr, irqAccept, stepIrq, fetchStart, cpuInReset;
   wire ramPreserve;
   int fails = 0, comparisons = 0, seed = 32'h6E42;
   always #10 clock = ~clock;
   cpurf_core #(.RESET_VECTOR(RV)) i_dut (
      .clock(clock), .sys_rst(sys_rst), .resetPin_n(resetPin_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .aluUpdate(aluUpdate), .aluCarry(aluCarry), .aluZero(aluZero),
      .aluSign(aluSign), .aluOverflow(aluOverflow), .instrDone(instrDone),
      .hwIntAck(hwIntAck), .swIntExec(swIntExec), .swIntNum(swIntNum),
      .irqRequest(irqRequest), .irqPriority(irqPriority),
      .irqAccept(irqAccept), .stepIrq(stepIrq), .fetchStart(fetchStart),
      .fetchAddr(fetchAddr), .cpuInReset(cpuInReset),
      .ramPreserve(ramPreserve));
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Entered just after an edge; d is write data or the expected read
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, m, input logic r);
      notes.push_back(cpurf_note_t'{w ? 32'h0 : d, w ? 32'h0 : m, r});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : $random(seed);
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic selw(input logic [4:0] c, input logic [31:0] d);
      apb(1'b1, `CPURF_OFS_SEL, {27'h0, c}, '0, 1'b0);
      apb(1'b1, `CPURF_OFS_DATA, d, '0, 1'b0);
   endtask
   task automatic selr(input logic [4:0] c, input logic [31:0] e);
      apb(1'b1, `CPURF_OFS_SEL, {27'h0, c}, '0, 1'b0);
      apb(1'b0, `CPURF_OFS_DATA, e, '1, 1'b0);
   endtask
   task automatic wf(input logic [31:0] d);
      apb(1'b1, `CPURF_OFS_FLAG, d, '0, 1'b0);
   endtask
   task automatic rf(input logic [31:0] e);
      apb(1'b0, `CPURF_OFS_FLAG, e, '1, 1'b0);
   endtask
   // One-cycle event pulse; returns when its registered effect is visible
   task automatic ev(input logic [3:0] k, input logic [5:0] num);
      {aluUpdate, swIntExec, hwIntAck, instrDone} <= k;
      swIntNum <= num;
      @(posedge clock);
      {aluUpdate, swIntExec, hwIntAck, instrDone} <= 4'h0;
      @(posedge clock);
   endtask
   // Answer checker: each pready consumes the oldest note
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            chk("unexpected answer", 32'h1, 32'h0);
         end else begin
            n = notes.pop_front();
            chk("read data", n.e, prdata & n.m);
            chk("error flag", {31'h0, n.r}, {31'h0, pslverr});
         end
      end
   end
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      stop_test();
   end
   initial begin
      logic [31:0] d, m;
      int i;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      chk("fetch address", {12'h0, RV}, {12'h0, fetchAddr});
      chk("in reset", 32'h0, {31'h0, cpuInReset});
      for (int c = 0; c < 20; c++) begin
         d = $random(seed);
         m = (c == 8 || c == 9) ? 32'hFFFFF : (c > 12 && c < 17) ? 32'hFF :
            (c > 16) ? 32'hFFFFFFFF : 32'hFFFF;
         selw(c[4:0], d);
         selr(c[4:0], d & m);
      end
      $display("test register widths done");
      selw(`CPURF_SEL_DATA_PAIR_LOW, 32'h1234A55A);
      selr(`CPURF_SEL_R0, 32'hA55A);
      selr(`CPURF_SEL_R2, 32'h1234);
      selr(`CPURF_SEL_R0H, 32'hA5);
      selr(`CPURF_SEL_R0L, 32'h5A);
      selw(`CPURF_SEL_ADDR_REG_PAIR, 32'h98760FED);
      selr(`CPURF_SEL_A0, 32'h0FED);
      selr(`CPURF_SEL_A1, 32'h9876);
      wf(32'h10);
      selw(`CPURF_SEL_R0, 32'hBEEF);
      wf(32'h0);
      selr(`CPURF_SEL_R0, 32'hA55A);
      wf(32'h10);
      selr(`CPURF_SEL_R0, 32'hBEEF);
      wf(32'h90);
      selw(`CPURF_SEL_SP, 32'h1111);
      selr(`CPURF_SEL_USP, 32'h1111);
      wf(32'h10);
      selw(`CPURF_SEL_SP, 32'h2222);
      selr(`CPURF_SEL_ISP, 32'h2222);
      apb(1'b0, `CPURF_OFS_SEL, {27'h0, `CPURF_SEL_ISP}, '1, 1'b0);
      apb(1'b0, `CPURF_OFS_STAT, 32'h4, '1, 1'b0);
      apb(1'b0, `CPURF_OFS_MODE, 32'h0, '1, 1'b0);
      $display("test banks and halves done");
      wf(32'hFFFFFFFF);
      rf(32'h70FF);
      ev(4'h1, 6'h0);
      chk("step interrupt", 32'h1, {31'h0, stepIrq});
      ev(4'h2, 6'h0);
      rf(32'h703D);
      ev(4'h1, 6'h0);
      chk("step interrupt", 32'h0, {31'h0, stepIrq});
      wf(32'h3080);
      ev(4'h4, 6'h20);
      rf(32'h3080);
      ev(4'h4, 6'h1F);
      rf(32'h3000);
      {aluCarry, aluZero, aluSign, aluOverflow} <= 4'hB;
      ev(4'h8, 6'h0);
      rf(32'h3029);
      {aluCarry, aluZero, aluSign, aluOverflow} <= 4'h4;
      ev(4'h8, 6'h0);
      rf(32'h3004);
      $display("test flag events done");
      wf(32'h3040);
      for (int p = 0; p < 8; p++) begin
         irqRequest <= 1'b1;
         irqPriority <= p[2:0];
         repeat (2) @(posedge clock);
         chk("accept", {31'h0, p > 3}, {31'h0, irqAccept});
      end
      wf(32'h3000);
      repeat (2) @(posedge clock);
      chk("masked accept", 32'h0, {31'h0, irqAccept});
      irqRequest <= 1'b0;
      $display("test priority done");
      apb(1'b0, 12'h014, 32'h0, '1, 1'b1);
      apb(1'b1, 12'h0FC, $random(seed), '0, 1'b1);
      apb(1'b1, `CPURF_OFS_MODE, 32'h8, '0, 1'b0);
      i = 0;
      repeat (6) begin
         @(posedge clock);
         i += (fetchStart === 1'b1);
      end
      chk("fetch pulses", 32'h1, i);
      chk("ram kept", 32'h1, {31'h0, ramPreserve});
      rf(32'h0);
      $display("test software reset done");
      wf(32'h10);
      // A pulse shorter than the minimum count must be ignored
      resetPin_n <= 1'b0;
      repeat (10) @(posedge clock);
      resetPin_n <= 1'b1;
      repeat (6) @(posedge clock);
      rf(32'h10);
      // Held well past the synchroniser delay plus the minimum count
      resetPin_n <= 1'b0;
      repeat (30) @(posedge clock);
      chk("in reset", 32'h1, {31'h0, cpuInReset});
      resetPin_n <= 1'b1;
      repeat (10) @(posedge clock);
      chk("in reset", 32'h0, {31'h0, cpuInReset});
      rf(32'h0);
      $display("test pin reset done");
      chk("pending answers", 32'h0, notes.size());
      stop_test();
   end
endmodule
`default_nettype wire
